/* File: fvm_pkg.sv */
package fvm_pkg;

    // Register byte offsets
    localparam logic [7:0] FVM_OFF_STATUS = 8'h00;
    localparam logic [7:0] FVM_OFF_PIDX   = 8'h04;
    localparam logic [7:0] FVM_OFF_PW0    = 8'h08;
    localparam logic [7:0] FVM_OFF_PW1    = 8'h0C;
    localparam logic [7:0] FVM_OFF_PW2    = 8'h10;
    localparam logic [7:0] FVM_OFF_IRQST  = 8'h14;
    localparam logic [7:0] FVM_OFF_IRQMSK = 8'h18;
    localparam logic [7:0] FVM_OFF_MODE   = 8'h1C;

    // Status register bit positions
    localparam int FVM_ST_CCF  = 7;
    localparam int FVM_ST_ACC  = 5;
    localparam int FVM_ST_PV   = 4;
    localparam int FVM_ST_ADR  = 2;
    localparam int FVM_ST_VSU  = 1;
    localparam int FVM_ST_VSL  = 0;

    // Command codes
    localparam logic [7:0] FVM_CMD_EVB  = 8'h02;
    localparam logic [7:0] FVM_CMD_UMRG = 8'h0D;
    localparam logic [7:0] FVM_CMD_FMRG = 8'h0E;

    // Required parameter index per command
    localparam logic [2:0] FVM_PIDX_EVB = 3'h1;
    localparam logic [2:0] FVM_PIDX_MRG = 3'h2;

    // Margin encodings
    localparam logic [15:0] FVM_LVL_NORM = 16'h0000;
    localparam logic [15:0] FVM_LVL_ERSD = 16'h0001;
    localparam logic [15:0] FVM_LVL_PROG = 16'h0002;

    // Block map: two blocks selected by global address ranges
    localparam logic [23:0] FVM_PF_BASE = 24'hFF0000;
    localparam logic [23:0] FVM_PF_LAST = 24'hFFFFFF;
    localparam logic [23:0] FVM_EE_BASE = 24'h100000;
    localparam logic [23:0] FVM_EE_LAST = 24'h1001FF;

    localparam logic [1:0] FVM_RESP_OKAY   = 2'b00;
    localparam logic [1:0] FVM_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic acc;
        logic adr;
        logic vsu;
        logic vsl;
    } fvm_err_t;

    typedef struct packed {
        logic        start;
        logic [23:0] addr;
        logic        blk_ee;
    } fvm_scan_req_t;

endpackage : fvm_pkg

/* File: fvm_blank_scan.sv */
`timescale 1ns/10ps
module fvm_blank_scan
    import fvm_pkg::*;
#(
    parameter int PF_WORDS = 64,
    parameter int EE_WORDS = 16
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire fvm_scan_req_t req,
    input  wire logic [31:0]   rd_data,
    input  wire logic          rd_ecc_corr,
    input  wire logic          rd_ecc_fatal,
    output logic [15:0]        rd_word,
    output logic               busy,
    output logic               done,
    output fvm_err_t           err
);
    logic [15:0] idx_q;
    logic        ee_q;
    logic [15:0] last_w;

    assign last_w  = ee_q ? 16'(EE_WORDS - 1) : 16'(PF_WORDS - 1);
    assign rd_word = idx_q;

    // One array word read per cycle; errors accumulate across the scan
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy  <= 1'b0;
            done  <= 1'b0;
            idx_q <= 16'h0000;
            ee_q  <= 1'b0;
            err   <= '0;
        end else begin
            done <= 1'b0;
            if (req.start && !busy) begin
                busy  <= 1'b1;
                idx_q <= 16'h0000;
                ee_q  <= req.blk_ee;
                err   <= '0;
            end else if (busy) begin
                if (rd_data != 32'hFFFFFFFF || rd_ecc_corr || rd_ecc_fatal) begin
                    err.vsu <= 1'b1;
                end
                if (rd_data != 32'hFFFFFFFF || rd_ecc_fatal) begin
                    err.vsl <= 1'b1;
                end
                if (idx_q == last_w) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    idx_q <= idx_q + 16'h0001;
                end
            end
        end
    end
endmodule : fvm_blank_scan

/* File: fvm_sequencer.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Code 0x02 verifies block at 24-bit address
// - Launch verify on flag clear; set when done
// - Non-erased block sets both verify bits
// - Verify with index not 001 errors
// - Invalid block address flags address error
// - Upper bit any error; lower fatal error
// - Levels 0 normal, 1 erased, 2 programmed
// - Margin index not 010 or bad mode errors
// - Bad level errors; verify bits untouched
// - Code 0x0E field margin, special mode only
// - Field margin applies level then completes
module fvm_sequencer
    import fvm_pkg::*;
#(
    parameter int PF_WORDS = 64,
    parameter int EE_WORDS = 16
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] array_rd_data,
    input  wire logic        array_ecc_corr,
    input  wire logic        array_ecc_fatal,
    output logic [15:0]      array_rd_word,
    output logic             array_rd_ee,
    output logic [1:0]       pf_margin_level,
    output logic [1:0]       ee_margin_level,
    output logic             irq
);
    typedef enum {ST_IDLE, ST_CHECK, ST_SCAN, ST_DONE} fvm_state_t;
    fvm_state_t  state_q;

    logic [7:0]  status_q;
    logic [2:0]  pidx_q;
    logic [15:0] pw0_q, pw1_q, pw2_q;
    logic [3:0]  irq_st_q, irq_msk_q;
    logic        special_q;
    logic        user_mode_ok_q;
    logic [1:0]  pf_lvl_q, ee_lvl_q;
    logic        blk_ee_q;

    // Write channel capture: address and data may arrive in either order
    logic [7:0]  aw_q;
    logic [31:0] w_q;
    logic [3:0]  ws_q;
    logic        aw_have_q, w_have_q;

    wire         wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid;
    wire         rd_fire  = s_axi_arvalid && s_axi_arready;
    wire [23:0]  gaddr    = {pw0_q[7:0], pw1_q};
    wire [7:0]   cmd      = pw0_q[15:8];
    wire         in_pf    = gaddr >= FVM_PF_BASE && gaddr <= FVM_PF_LAST;
    wire         in_ee    = gaddr >= FVM_EE_BASE && gaddr <= FVM_EE_LAST;
    wire         addr_ok  = in_pf || in_ee;
    wire         lvl_ok   = pw2_q == FVM_LVL_NORM || pw2_q == FVM_LVL_ERSD
                            || pw2_q == FVM_LVL_PROG;
    wire         is_evb   = cmd == FVM_CMD_EVB;
    wire         is_umrg  = cmd == FVM_CMD_UMRG;
    wire         is_fmrg  = cmd == FVM_CMD_FMRG;
    wire         is_mrg   = is_umrg || is_fmrg;
    wire         mode_ok  = is_fmrg ? special_q : user_mode_ok_q;
    wire         pidx_bad = is_evb ? (pidx_q != FVM_PIDX_EVB)
                                   : (pidx_q != FVM_PIDX_MRG);
    wire         chk_acc  = pidx_bad || (is_mrg && !mode_ok)
                            || (is_mrg && !lvl_ok)
                            || !(is_evb || is_mrg);
    wire         chk_adr  = !addr_ok;
    wire         launch   = wr_fire && aw_q == FVM_OFF_STATUS && ws_q[0]
                            && w_q[FVM_ST_CCF] && status_q[FVM_ST_CCF]
                            && state_q == ST_IDLE;

    fvm_scan_req_t scan_req;
    fvm_err_t      scan_err;
    logic          scan_busy, scan_done;
    logic [15:0]   array_rd_word_w;

    assign scan_req.start  = state_q == ST_CHECK && !chk_acc && !chk_adr && is_evb;
    assign scan_req.addr   = gaddr;
    assign scan_req.blk_ee = in_ee;

    fvm_blank_scan #(
        .PF_WORDS (PF_WORDS),
        .EE_WORDS (EE_WORDS)
    ) u_scan (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .req          (scan_req),
        .rd_data      (array_rd_data),
        .rd_ecc_corr  (array_ecc_corr),
        .rd_ecc_fatal (array_ecc_fatal),
        .rd_word      (array_rd_word_w),
        .busy         (scan_busy),
        .done         (scan_done),
        .err          (scan_err)
    );

    // Event set bits: complete, access error, address error, verify fail
    wire [3:0] ev = {state_q == ST_DONE,
                     state_q == ST_CHECK && chk_acc,
                     state_q == ST_CHECK && chk_adr,
                     scan_done && (scan_err.vsu || scan_err.vsl)};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_q      <= 8'h00;
            w_q       <= 32'h00000000;
            ws_q      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_q      <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_q      <= s_axi_wdata;
                ws_q     <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= FVM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) s_axi_awready <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)   s_axi_wready  <= 1'b0;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_q > FVM_OFF_MODE || aw_q[1:0] != 2'b00)
                                ? FVM_RESP_SLVERR : FVM_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read path; a status-irq read clears it, keeping only an event that lands the same cycle
    logic [31:0] rd_mux;
    logic        rd_bad;
    always_comb begin
        rd_mux = 32'h00000000;
        rd_bad = 1'b0;
        unique case (s_axi_araddr)
            FVM_OFF_STATUS: rd_mux = {24'h000000, status_q};
            FVM_OFF_PIDX:   rd_mux = {29'h0, pidx_q};
            FVM_OFF_PW0:    rd_mux = {16'h0000, pw0_q};
            FVM_OFF_PW1:    rd_mux = {16'h0000, pw1_q};
            FVM_OFF_PW2:    rd_mux = {16'h0000, pw2_q};
            FVM_OFF_IRQST:  rd_mux = {28'h0, irq_st_q};
            FVM_OFF_IRQMSK: rd_mux = {28'h0, irq_msk_q};
            FVM_OFF_MODE:   rd_mux = {26'h0, ee_lvl_q, pf_lvl_q, user_mode_ok_q,
                                      special_q};
            default:        rd_bad = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= FVM_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_bad ? FVM_RESP_SLVERR : FVM_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    wire w_hit_pidx = wr_fire && aw_q == FVM_OFF_PIDX && ws_q[0];
    wire w_hit_pw0  = wr_fire && aw_q == FVM_OFF_PW0 && state_q == ST_IDLE;
    wire w_hit_pw1  = wr_fire && aw_q == FVM_OFF_PW1 && state_q == ST_IDLE;
    wire w_hit_pw2  = wr_fire && aw_q == FVM_OFF_PW2 && state_q == ST_IDLE;
    wire w_hit_msk  = wr_fire && aw_q == FVM_OFF_IRQMSK && ws_q[0];
    wire w_hit_mode = wr_fire && aw_q == FVM_OFF_MODE && ws_q[0];
    wire w_clr_err  = wr_fire && aw_q == FVM_OFF_STATUS && ws_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pidx_q         <= 3'h0;
            pw0_q          <= 16'h0000;
            pw1_q          <= 16'h0000;
            pw2_q          <= 16'h0000;
            irq_msk_q      <= 4'h0;
            special_q      <= 1'b0;
            user_mode_ok_q <= 1'b1;
        end else begin
            if (w_hit_pidx) pidx_q <= w_q[2:0];
            if (w_hit_pw0)  pw0_q  <= w_q[15:0];
            if (w_hit_pw1)  pw1_q  <= w_q[15:0];
            if (w_hit_pw2)  pw2_q  <= w_q[15:0];
            if (w_hit_msk)  irq_msk_q <= w_q[3:0];
            if (w_hit_mode) begin
                special_q      <= w_q[0];
                user_mode_ok_q <= w_q[1];
            end
        end
    end

    wire rd_irqst = rd_fire && s_axi_araddr == FVM_OFF_IRQST;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st_q <= 4'h0;
            irq      <= 1'b0;
        end else begin
            irq_st_q <= (rd_irqst ? 4'h0 : irq_st_q) | ev;
            irq      <= |(((rd_irqst ? 4'h0 : irq_st_q) | ev) & irq_msk_q);
        end
    end

    // Sequencer: idle, one-cycle checks, optional scan, complete
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q  <= ST_IDLE;
            status_q <= 8'h80;
            pf_lvl_q <= FVM_LVL_NORM[1:0];
            ee_lvl_q <= FVM_LVL_NORM[1:0];
            blk_ee_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (w_clr_err) begin
                        if (w_q[FVM_ST_ACC]) status_q[FVM_ST_ACC] <= 1'b0;
                        if (w_q[FVM_ST_PV])  status_q[FVM_ST_PV]  <= 1'b0;
                        if (w_q[FVM_ST_ADR]) status_q[FVM_ST_ADR] <= 1'b0;
                    end
                    // A pending access error blocks launch unless the same write clears it; complete stays set
                    if (launch && (w_q[FVM_ST_ACC] || !status_q[FVM_ST_ACC])) begin
                        status_q[FVM_ST_CCF] <= 1'b0;
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    status_q[FVM_ST_ACC] <= chk_acc;
                    status_q[FVM_ST_ADR] <= chk_adr;
                    if (!is_mrg) begin
                        status_q[FVM_ST_VSU] <= 1'b0;
                        status_q[FVM_ST_VSL] <= 1'b0;
                    end
                    blk_ee_q <= in_ee;
                    if (chk_acc || chk_adr) begin
                        state_q <= ST_DONE;
                    end else if (is_evb) begin
                        state_q <= ST_SCAN;
                    end else begin
                        if (in_ee) ee_lvl_q <= pw2_q[1:0];
                        else       pf_lvl_q <= pw2_q[1:0];
                        state_q <= ST_DONE;
                    end
                end
                ST_SCAN: begin
                    if (scan_done) begin
                        status_q[FVM_ST_VSU] <= scan_err.vsu;
                        status_q[FVM_ST_VSL] <= scan_err.vsl;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    status_q[FVM_ST_CCF] <= 1'b1;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            array_rd_word   <= 16'h0000;
            array_rd_ee     <= 1'b0;
            pf_margin_level <= FVM_LVL_NORM[1:0];
            ee_margin_level <= FVM_LVL_NORM[1:0];
        end else begin
            array_rd_word   <= array_rd_word_w;
            array_rd_ee     <= blk_ee_q;
            pf_margin_level <= pf_lvl_q;
            ee_margin_level <= ee_lvl_q;
        end
    end
endmodule : fvm_sequencer

/* File: fvm_sequencer_sva.sv */
`timescale 1ns/10ps
module fvm_sequencer_sva
    import fvm_pkg::*;
#(
    parameter int PF_WORDS = 64,
    parameter int EE_WORDS = 16
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [15:0] array_rd_word,
    input wire logic [1:0]  pf_margin_level,
    input wire logic [1:0]  ee_margin_level
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Cycles since the last write address; saturates so idle stretches never wrap
    logic [3:0] since_wr_q;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            since_wr_q <= 4'hF;
        else if (s_axi_awvalid && s_axi_awready)
            since_wr_q <= 4'h0;
        else if (since_wr_q != 4'hF)
            since_wr_q <= since_wr_q + 4'h1;
    end

    chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    chk_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C
        |=> s_axi_rresp == FVM_RESP_SLVERR) else $error("unmapped read not refused");
    chk_level_legal: assert property (pf_margin_level != 2'h3 && ee_margin_level != 2'h3)
        else $error("illegal margin level");
    chk_margin_cause: assert property (aresetn && ($changed(pf_margin_level)
        || $changed(ee_margin_level)) |-> since_wr_q <= 4'h5)
        else $error("margin changed without a command");
    chk_scan_step: assert property ($changed(array_rd_word)
        |-> array_rd_word == $past(array_rd_word) + 16'h1 || array_rd_word == 16'h0)
        else $error("scan skipped a word");
    chk_scan_range: assert property (array_rd_word < PF_WORDS)
        else $error("scan index beyond block");
endmodule : fvm_sequencer_sva

bind fvm_sequencer fvm_sequencer_sva #(.PF_WORDS(PF_WORDS), .EE_WORDS(EE_WORDS)) u_fvm_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp),
    .array_rd_word(array_rd_word), .pf_margin_level(pf_margin_level),
    .ee_margin_level(ee_margin_level));

/* File: fvm_sequencer_tb.sv */
`timescale 1ns/10ps
module fvm_sequencer_tb
    import fvm_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, arvalid, ecc_corr, ecc_fatal;
    logic        awready, wready, bvalid, arready, rvalid, rd_ee, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd_data, st, v, bad;
    logic [1:0]  bresp, rresp, r, pf_lvl, ee_lvl;
    logic [15:0] rd_word, seed;
    int          miscompares, n_checks, flt;

    fvm_sequencer #(.PF_WORDS(32), .EE_WORDS(8)) u_fvm_sequencer (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .array_rd_data(rd_data), .array_ecc_corr(ecc_corr), .array_ecc_fatal(ecc_fatal),
        .array_rd_word(rd_word), .array_rd_ee(rd_ee), .pf_margin_level(pf_lvl),
        .ee_margin_level(ee_lvl), .irq(irq));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Fault applies to every word, so read latency of the scan does not matter
    always @(posedge aclk) begin
        rd_data   <= (flt == 1) ? bad : 32'hFFFFFFFF;
        ecc_corr  <= (flt == 2);
        ecc_fatal <= (flt == 3);
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [31:0] exp_vs(input int k);
        return {30'h0, k != 0, k == 1 || k == 3};
    endfunction : exp_vs

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic end_of_test;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d  = rdata;
        rr = rresp;
    endtask : rd

    task automatic run(input logic [2:0] px, input logic [7:0] c, input logic [23:0] a,
                       input logic [15:0] l);
        int n;
        n = 0;
        wr(FVM_OFF_PIDX, {29'h0, px});
        wr(FVM_OFF_PW0, {16'h0, c, a[23:16]});
        wr(FVM_OFF_PW1, {16'h0, a[15:0]});
        wr(FVM_OFF_PW2, {16'h0, l});
        wr(FVM_OFF_STATUS, 32'h20);
        wr(FVM_OFF_STATUS, 32'h80);
        do begin
            rd(FVM_OFF_STATUS, st, r);
            n++;
        end while (!st[7] && n < 400);
    endtask : run

    // Refused command: error flagged, verify bits and both levels kept
    task automatic rej(input logic [2:0] px, input logic [7:0] c, input logic [23:0] a,
                       input logic [15:0] l, input logic [31:0] m);
        wr(FVM_OFF_MODE, m);
        run(px, c, a, l);
        cmp({31'h0, |(st & 32'h34)}, 32'h1);
        cmp(st & 32'h83, 32'h83);
        cmp({28'h0, pf_lvl, ee_lvl}, 32'hA);
    endtask : rej

    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        end_of_test;
    end

    initial begin
        aresetn   = 1'b0;
        awvalid   = 1'b0;
        wvalid    = 1'b0;
        arvalid   = 1'b0;
        awaddr    = 8'h00;
        araddr    = 8'h00;
        wdata     = 32'h0;
        rd_data   = 32'hFFFFFFFF;
        ecc_corr  = 1'b0;
        ecc_fatal = 1'b0;
        flt       = 0;
        seed      = 16'hE4CF;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(FVM_OFF_STATUS, v, r);
        cmp(v, 32'h80);
        rd(8'h24, v, r);
        cmp({30'h0, r}, {30'h0, FVM_RESP_SLVERR});
        wr(8'h24, 32'h0);
        cmp({30'h0, bresp}, {30'h0, FVM_RESP_SLVERR});
        wr(FVM_OFF_IRQMSK, 32'h8);
        cmp({30'h0, bresp}, {30'h0, FVM_RESP_OKAY});
        $display("test reset done");
        seed = lfsr(seed);
        run((seed[2:0] == 3'h1) ? 3'h5 : seed[2:0], FVM_CMD_EVB, {8'hFF, seed}, 16'h0);
        cmp(st & 32'hB7, 32'hA0);
        cmp({31'h0, irq}, 32'h1);
        rd(FVM_OFF_IRQST, v, r);
        cmp(v, 32'hC);
        rd(FVM_OFF_IRQST, v, r);
        cmp(v | {31'h0, irq}, 32'h0);
        wr(FVM_OFF_IRQMSK, 32'h0);
        run(3'h1, FVM_CMD_EVB, 24'h200000 | {8'h0, seed}, 16'h0);
        cmp(st & 32'h84, 32'h84);
        cmp({31'h0, irq}, 32'h0);
        rd(FVM_OFF_IRQST, v, r);
        cmp(v & 32'h2, 32'h2);
        $display("test errors done");
        for (int b = 0; b < 2; b++) begin
            for (int k = 0; k < 4; k++) begin
                seed = lfsr(seed);
                bad  = {1'b0, seed, seed[14:0]};
                flt <= k;
                run(3'h1, FVM_CMD_EVB, b ? FVM_EE_BASE + {15'h0, seed[8:0]} : {8'hFF, seed},
                    16'h0);
                cmp(st & 32'hB7, 32'h80 | exp_vs(k));
                cmp({31'h0, rd_ee}, b[31:0]);
            end
        end
        flt <= 0;
        $display("test verify done");
        wr(FVM_OFF_MODE, 32'h2);
        for (int b = 0; b < 2; b++) begin
            for (int l = 0; l < 3; l++) begin
                run(FVM_PIDX_MRG, FVM_CMD_UMRG, b ? FVM_EE_LAST : FVM_PF_BASE, l[15:0]);
                cmp(st & 32'hB7, 32'h83);
                cmp({30'h0, b ? ee_lvl : pf_lvl}, l);
            end
        end
        rej(3'h2, FVM_CMD_UMRG, FVM_PF_BASE, 16'h3, 32'h2);
        rej(3'h1, FVM_CMD_UMRG, FVM_PF_BASE, 16'h1, 32'h2);
        rej(3'h2, FVM_CMD_UMRG, FVM_PF_BASE, 16'h1, 32'h0);
        rej(3'h2, FVM_CMD_UMRG, 24'h200000, 16'h1, 32'h2);
        rej(3'h2, FVM_CMD_FMRG, FVM_PF_BASE, 16'h1, 32'h0);
        wr(FVM_OFF_MODE, 32'h1);
        run(FVM_PIDX_MRG, FVM_CMD_FMRG, FVM_PF_LAST, 16'h1);
        cmp({28'h0, pf_lvl, ee_lvl}, 32'h6);
        // Blank check repeated while the program block reads at a margin level
        run(3'h1, FVM_CMD_EVB, FVM_PF_BASE, 16'h0);
        cmp(st & 32'hB7, 32'h80);
        cmp({28'h0, pf_lvl, ee_lvl}, 32'h6);
        $display("test margin done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp({28'h0, pf_lvl, ee_lvl}, 32'h0);
        rd(FVM_OFF_STATUS, v, r);
        cmp(v, 32'h80);
        $display("test rereset done");
        end_of_test;
    end
endmodule : fvm_sequencer_tb
